// >>> src/bus_cycle_defs.svh
// constants for the bus cycle sequencer: vector page, page-two prefix, reset values, depth
// assumes inclusion by bare name from the package and the sequencer module
// Notes on behaviour
// - core can insert free cycles that make no functional use of the buses
// - free cycle lasts one bus clock and runs as a read, never a write
// - program fetch reads next sequential location and advances program counter
// - operand read moves one byte from addressed location into the core
// - operand write drives one byte to the computed effective address
// - stack push writes one byte at stack pointer address
// - stack pop reads one byte from stack and returns it to core
// - vector fetch reads top page, high byte first then low byte
// - indexed no-offset mode with index post increment
// - indexed byte-offset mode with index post increment
// - indexed word-offset mode adds 16-bit offset to full index pair
// - stack-relative mode adds byte or word offset to stack pointer
// - prefix byte before opcode selects second opcode page; the sequencer honours it only before the first opcode after reset
`ifndef BUS_CYCLE_DEFS_SVH
`define BUS_CYCLE_DEFS_SVH
`define VECTOR_PAGE 8'hFF
`define PAGE2_PREFIX 8'h9E
`define STACK_RESET 16'h00FF
`define PC_RESET 16'h0000
`define IDX_RESET 16'h0000
`define SEQ_DEPTH 16
`endif

// >>> src/bus_cycle_pkg.sv
// types for the bus cycle sequencer: cycle codes, address modes, bundles
// assumes the defs header sits on the include path
`include "bus_cycle_defs.svh"
package bus_cycle_pkg;
   typedef enum logic [2:0] {
      CYC_FREE, CYC_FETCH, CYC_READ, CYC_WRITE, CYC_PUSH, CYC_POP, CYC_VECTOR
   } cycle_code_type;
   typedef enum logic [2:0] {
      MODE_NONE, MODE_INDEX, MODE_INDEX_POST, MODE_INDEX_BYTE,
      MODE_INDEX_BYTE_POST, MODE_INDEX_WORD, MODE_STACK_BYTE, MODE_STACK_WORD
   } addr_mode_type;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic write;
      logic valid;
      logic free;
   } bus_req_type;
   typedef struct packed {
      cycle_code_type code;
      addr_mode_type mode;
      logic [15:0] offset;
      logic [7:0] wdata;
      logic [7:0] vector_lo;
   } cycle_cmd_type;
endpackage

// >>> src/cpu_bus_cycle_sequencer.sv
// bus cycle sequencer: one cycle code per clock drives address, data, direction
// assumes decoder presents a command every cycle; memory answers read data same cycle
`timescale 1ns/1ps
`include "bus_cycle_defs.svh"
module cpu_bus_cycle_sequencer
   import bus_cycle_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire cycle_cmd_type cmd,
   input wire logic cmd_valid,
   input wire logic [7:0] bus_rdata,
   input wire logic pc_load,
   input wire logic [15:0] pc_load_value,
   input wire logic sp_load,
   input wire logic [15:0] sp_load_value,
   input wire logic idx_load,
   input wire logic [15:0] idx_load_value,
   output bus_req_type bus_req,
   output logic [7:0] read_data,
   output logic read_valid,
   output logic [7:0] opcode,
   output logic opcode_valid,
   output logic page2,
   output logic [15:0] program_counter,
   output logic [15:0] stack_pointer,
   output logic [15:0] index_pair,
   output logic [15:0] vector_value,
   output logic [7:0] cycle_count
);
   ////////////////////////////////////////////////////////////////////////
   // state
   logic [15:0] pc_reg, pc_next;
   logic [15:0] sp_reg, sp_next;
   logic [15:0] idx_reg, idx_next;
   logic [7:0] vec_hi_reg;
   logic vec_hi_seen_reg;
   logic [15:0] vec_reg;
   logic page2_reg, page2_next;
   logic opcode_due_reg;
   logic [7:0] count_reg;
   bus_req_type req_reg;
   logic [7:0] rdata_reg;
   logic rvalid_reg;
   logic [7:0] opcode_reg;
   logic opvalid_reg;

   ////////////////////////////////////////////////////////////////////////
   // effective address
   function automatic logic [15:0] eff_addr(input addr_mode_type m, input logic [15:0] off,
                                            input logic [15:0] ix, input logic [15:0] sp);
      logic [15:0] a;
      a = off;
      case (m)
         MODE_INDEX, MODE_INDEX_POST: a = ix;
         MODE_INDEX_BYTE, MODE_INDEX_BYTE_POST: a = ix + {8'h00, off[7:0]};
         MODE_INDEX_WORD: a = ix + off;
         MODE_STACK_BYTE: a = sp + {8'h00, off[7:0]};
         MODE_STACK_WORD: a = sp + off;
         default: a = off;
      endcase
      return a;
   endfunction

   function automatic logic post_inc(input addr_mode_type m);
      return (m == MODE_INDEX_POST) || (m == MODE_INDEX_BYTE_POST);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode of the current command
   // cycle kinds and what they put on the bus:
   //    free   - read at the program counter, data thrown away
   //    fetch  - read at the program counter, counter steps on
   //    read   - read at the effective address
   //    write  - write at the effective address
   //    push   - write at the stack pointer, pointer steps down
   //    pop    - read above the stack pointer, pointer steps up
   //    vector - read in the top page, high byte then low
   wire logic is_free = cmd_valid && (cmd.code == CYC_FREE);
   wire logic is_fetch = cmd_valid && (cmd.code == CYC_FETCH);
   wire logic is_read = cmd_valid && (cmd.code == CYC_READ);
   wire logic is_write = cmd_valid && (cmd.code == CYC_WRITE);
   wire logic is_push = cmd_valid && (cmd.code == CYC_PUSH);
   wire logic is_pop = cmd_valid && (cmd.code == CYC_POP);
   wire logic is_vector = cmd_valid && (cmd.code == CYC_VECTOR);
   wire logic [15:0] ea = eff_addr(cmd.mode, cmd.offset, idx_reg, sp_reg);
   wire logic [15:0] pop_addr = sp_reg + 16'h0001;
   wire logic [15:0] vec_addr = {`VECTOR_PAGE, cmd.vector_lo};
   wire logic is_prefix = is_fetch && opcode_due_reg && (bus_rdata == `PAGE2_PREFIX);

   // bus request selection
   bus_req_type req_next;
   always_comb begin
      req_next = '0;
      req_next.valid = cmd_valid;
      if (is_free) begin
         req_next.addr = pc_reg;
         req_next.free = 1'b1;
      end else if (is_fetch) begin
         req_next.addr = pc_reg;
      end else if (is_read) begin
         req_next.addr = ea;
      end else if (is_write) begin
         req_next.addr = ea;
         req_next.wdata = cmd.wdata;
         req_next.write = 1'b1;
      end else if (is_push) begin
         req_next.addr = sp_reg;
         req_next.wdata = cmd.wdata;
         req_next.write = 1'b1;
      end else if (is_pop) begin
         req_next.addr = pop_addr;
      end else if (is_vector) begin
         req_next.addr = vec_addr;
      end
   end

   // register updates
   always_comb begin
      pc_next = pc_reg;
      sp_next = sp_reg;
      idx_next = idx_reg;
      page2_next = page2_reg;
      if (is_fetch) begin
         pc_next = pc_reg + 16'h0001;
      end
      if (is_push) begin
         sp_next = sp_reg - 16'h0001;
      end else if (is_pop) begin
         sp_next = pop_addr;
      end
      if ((is_read || is_write) && post_inc(cmd.mode)) begin
         idx_next = idx_reg + 16'h0001;
      end
      // page flag stays up through the opcode pulse so the decoder can qualify it
      if (is_prefix) begin
         page2_next = 1'b1;
      end else if (opvalid_reg) begin
         page2_next = 1'b0;
      end
      if (pc_load) begin
         pc_next = pc_load_value;
      end
      if (sp_load) begin
         sp_next = sp_load_value;
      end
      if (idx_load) begin
         idx_next = idx_load_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pointers and page flag
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pc_reg <= `PC_RESET;
         sp_reg <= `STACK_RESET;
         idx_reg <= `IDX_RESET;
         page2_reg <= 1'b0;
      end else begin
         pc_reg <= pc_next;
         sp_reg <= sp_next;
         idx_reg <= idx_next;
         page2_reg <= page2_next;
      end
   end

   // opcode tracking: after a prefix the next fetch is the page-two opcode
   // limitation: no boundary input, so only the first opcode after reset is marked
   always_ff @(posedge core_clk) begin
      if (rst) begin
         opcode_due_reg <= 1'b1;
         opcode_reg <= 8'h00;
         opvalid_reg <= 1'b0;
      end else begin
         opvalid_reg <= is_fetch && opcode_due_reg && !is_prefix;
         if (is_fetch && opcode_due_reg) begin
            opcode_reg <= bus_rdata;
            opcode_due_reg <= is_prefix;
         end else if (opvalid_reg) begin
            opcode_due_reg <= 1'b0;
         end
      end
   end

   // bus request and read capture, one code per clock
   always_ff @(posedge core_clk) begin
      if (rst) begin
         req_reg <= '0;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         req_reg <= req_next;
         rvalid_reg <= is_read || is_pop;
         if (is_read || is_pop || is_fetch) begin
            rdata_reg <= bus_rdata;
         end
      end
   end

   // vector assembly, high byte first
   always_ff @(posedge core_clk) begin
      if (rst) begin
         vec_hi_reg <= 8'h00;
         vec_hi_seen_reg <= 1'b0;
         vec_reg <= 16'h0000;
      end else if (is_vector) begin
         if (!vec_hi_seen_reg) begin
            vec_hi_reg <= bus_rdata;
            vec_hi_seen_reg <= 1'b1;
         end else begin
            vec_reg <= {vec_hi_reg, bus_rdata};
            vec_hi_seen_reg <= 1'b0;
         end
      end
   end

   // cycle counter, restarts at 1 on the first prefix or opcode fetch after reset, not on a page-two opcode
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_reg <= 8'h00;
      end else if (is_fetch && opcode_due_reg && !page2_reg) begin
         count_reg <= 8'h01;
      end else if (cmd_valid) begin
         count_reg <= count_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign bus_req = req_reg;
   assign read_data = rdata_reg;
   assign read_valid = rvalid_reg;
   assign opcode = opcode_reg;
   assign opcode_valid = opvalid_reg;
   assign page2 = page2_reg;
   assign program_counter = pc_reg;
   assign stack_pointer = sp_reg;
   assign index_pair = idx_reg;
   assign vector_value = vec_reg;
   assign cycle_count = count_reg;
endmodule

// >>> verif/bus_memory_model.sv
// memory on the system bus: same-cycle read, bytes stored from write cycles
// assumes the bench puts the address of the coming read on look_addr
`timescale 1ns/1ps
module bus_memory_model
   import bus_cycle_pkg::*;
(
   input wire logic core_clk,
   input wire bus_req_type bus_req,
   input wire logic [15:0] look_addr,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:65535];
   // fill with a pattern of the address bytes
   initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
   // reads answer combinationally
   assign rdata = mem[look_addr];
   // store written bytes
   always @(posedge core_clk) begin
      if (bus_req.valid && bus_req.write) mem[bus_req.addr] <= bus_req.wdata;
   end
endmodule

// >>> verif/cpu_bus_cycle_sequencer_chk.sv
// checker for the sequencer: bus cycles, pointers and cycle count
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_chk
   import bus_cycle_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire cycle_cmd_type cmd,
   input wire logic cmd_valid,
   input wire logic [7:0] bus_rdata,
   input wire logic pc_load,
   input wire logic sp_load,
   input wire logic idx_load,
   input wire bus_req_type bus_req,
   input wire logic [7:0] read_data,
   input wire logic read_valid,
   input wire logic [15:0] program_counter,
   input wire logic [15:0] stack_pointer,
   input wire logic [15:0] index_pair,
   input wire logic [7:0] cycle_count
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // one property per cycle kind, plus the idle and count checks
   a_free_as_read:
      assert property (cmd_valid && cmd.code == CYC_FREE |=> bus_req.free && !bus_req.write)
      else $error("free cycle wrong");
   a_idle_quiet:
      assert property (!cmd_valid |=> !bus_req.valid) else $error("idle cycle on bus");
   a_count_step:
      assert property (cmd_valid && cmd.code != CYC_FETCH |=>
         bus_req.valid && cycle_count == $past(cycle_count) + 8'h01) else $error("count wrong");
   a_fetch_next:
      assert property (cmd_valid && cmd.code == CYC_FETCH && !pc_load |=>
         bus_req.addr == $past(program_counter) && program_counter == $past(program_counter) + 16'h0001)
      else $error("fetch wrong");
   a_push_write:
      assert property (cmd_valid && cmd.code == CYC_PUSH && !sp_load |=> bus_req.write
         && bus_req.addr == $past(stack_pointer) && stack_pointer == $past(stack_pointer) - 16'h0001)
      else $error("push wrong");
   a_pop_read:
      assert property (cmd_valid && cmd.code == CYC_POP && !sp_load |=> !bus_req.write
         && read_valid && read_data == $past(bus_rdata) && bus_req.addr == stack_pointer)
      else $error("pop wrong");
   a_vector_page:
      assert property (cmd_valid && cmd.code == CYC_VECTOR |=>
         bus_req.addr == {8'hFF, $past(cmd.vector_lo)}) else $error("vector address wrong");
   a_word_write:
      assert property (cmd_valid && cmd.code == CYC_WRITE && cmd.mode == MODE_INDEX_WORD && !idx_load
         |=> bus_req.write && bus_req.wdata == $past(cmd.wdata)
         && bus_req.addr == $past(index_pair) + $past(cmd.offset)) else $error("write wrong");
   a_post_inc:
      assert property (cmd_valid && cmd.code == CYC_READ && cmd.mode == MODE_INDEX_POST && !idx_load
         |=> index_pair == $past(index_pair) + 16'h0001) else $error("post increment wrong");
endmodule
////////////////////////////////////////
bind cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_chk chk_i (.core_clk(core_clk), .rst(rst),
   .cmd(cmd), .cmd_valid(cmd_valid), .bus_rdata(bus_rdata), .pc_load(pc_load),
   .sp_load(sp_load), .idx_load(idx_load), .bus_req(bus_req), .read_data(read_data),
   .read_valid(read_valid), .program_counter(program_counter), .stack_pointer(stack_pointer),
   .index_pair(index_pair), .cycle_count(cycle_count));

// >>> verif/cpu_bus_cycle_sequencer_test.sv
// testbench for the sequencer: fetch, free, stack, modes, vector
// assumes the memory model answers reads in the same cycle
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_test
   import bus_cycle_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   cycle_cmd_type cmd = '0;
   logic cmd_valid = 1'b0, idx_load = 1'b0, rv, ov, page2;
   logic [15:0] idx_value = '0, look = '0, pc, sp, ix, vec;
   logic [7:0] rdata, rd, op, cnt;
   bus_req_type req;
   int bad_count = 0, total_checks = 0;
   cpu_bus_cycle_sequencer DUT (.core_clk(core_clk), .rst(rst), .cmd(cmd), .cmd_valid(cmd_valid),
      .bus_rdata(rdata), .pc_load(1'b0), .pc_load_value(16'h0000), .sp_load(1'b0),
      .sp_load_value(16'h0000), .idx_load(idx_load), .idx_load_value(idx_value), .bus_req(req),
      .read_data(rd), .read_valid(rv), .opcode(op), .opcode_valid(ov), .page2(page2),
      .program_counter(pc), .stack_pointer(sp), .index_pair(ix), .vector_value(vec),
      .cycle_count(cnt));
   bus_memory_model mem_i (.core_clk(core_clk), .bus_req(req), .look_addr(look), .rdata(rdata));
   initial forever #2.5 core_clk = ~core_clk;
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (bad_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // present one code; the next edge takes it
   task automatic issue(input cycle_code_type c, input addr_mode_type m, input logic [15:0] o,
      input logic [7:0] w, input logic [7:0] v, input logic [15:0] a);
      @(posedge core_clk);
      cmd <= '{c, m, o, w, v};
      cmd_valid <= 1'b1;
      look <= a;
   endtask
   task automatic settle;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      #1;
   endtask
   task automatic t_fetch;
      mem_i.mem[16'h0000] = 8'h9E;
      issue(CYC_FETCH, MODE_NONE, 16'h0000, 8'h00, 8'h00, 16'h0000);
      issue(CYC_FETCH, MODE_NONE, 16'h0000, 8'h00, 8'h00, 16'h0001);
      settle;
      chk({page2, ov, op, req.addr}, {1'b1, 1'b1, 8'h01, 16'h0001});
      chk(cnt, 8'h02);
      issue(CYC_FREE, MODE_NONE, 16'h0000, 8'h00, 8'h00, 16'h0002);
      settle;
      chk({req.free, req.write, pc}, {2'b10, 16'h0002});
      chk(cnt, 8'h03);
   endtask
   task automatic t_stack;
      issue(CYC_PUSH, MODE_NONE, 16'h0000, 8'hA5, 8'h00, 16'h00FF);
      settle;
      chk({req.write, req.wdata, sp}, {1'b1, 8'hA5, 16'h00FE});
      issue(CYC_POP, MODE_NONE, 16'h0000, 8'h00, 8'h00, 16'h00FF);
      settle;
      chk({rv, rd, sp}, {1'b1, 8'hA5, 16'h00FF});
   endtask
   task automatic t_modes;
      logic [15:0] ea, ie;
      @(posedge core_clk);
      idx_load <= 1'b1;
      idx_value <= 16'h1234;
      @(posedge core_clk);
      idx_load <= 1'b0;
      ie = 16'h1234;
      for (int m = 0; m < 8; m++) begin
         ea = (m == 0) ? 16'h0000 : (m < 6) ? ie : 16'h00FF;
         ea += (m == 3 || m == 4 || m == 6) ? 16'h0080 : (m == 0 || m > 4) ? 16'h0180 : 16'h0000;
         issue(CYC_READ, addr_mode_type'(m), 16'h0180, 8'h00, 8'h00, ea);
         settle;
         if (m == 2 || m == 4) ie++;
         chk({rd, req.addr}, {pat(ea), ea});
         chk(ix, ie);
      end
      issue(CYC_WRITE, MODE_INDEX_WORD, 16'h0100, 8'h5A, 8'h00, 16'h0000);
      settle;
      chk({req.wdata, req.addr}, {8'h5A, ie + 16'h0100});
      issue(CYC_READ, MODE_INDEX_WORD, 16'h0100, 8'h00, 8'h00, ie + 16'h0100);
      settle;
      chk(rd, 8'h5A);
   endtask
   task automatic t_vector;
      issue(CYC_VECTOR, MODE_NONE, 16'h0000, 8'h00, 8'hFE, 16'hFFFE);
      issue(CYC_VECTOR, MODE_NONE, 16'h0000, 8'h00, 8'hFF, 16'hFFFF);
      settle;
      chk({req.addr, vec[7:0]}, {16'hFFFF, 8'h00});
      chk(vec, 16'h0100);
   endtask
   ////////////////////////////////////////
   // main sequence and hang guard
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      t_fetch;
      t_stack;
      t_modes;
      t_vector;
      end_sim;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      end_sim;
   end
endmodule
